/* rtl/internal_32k_osc_control.sv */
/*
  Control of the internal 32 kHz oscillator and the ultra-low-power 32 kHz
  oscillator register: enable and run decision, standby and on-request
  behaviour, output gate, trims, write locks, start-up count and ready flag,
  with sticky ready events on one interrupt output.
  Assumes the peripheral request, standby indication and flash trim come
  from logic on clk; the two oscillator clocks arrive as raw pins.
*/
// Our own choice: strobed register access.
`timescale 1ns/1ns

module internal_32k_osc_control (
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rd_data,
  // system inputs
  input  wire logic        peripheral_request,
  input  wire logic        standby_sleep,
  input  wire logic [4:0]  flash_ulp_trim,
  input  wire logic        ulp_clk_pin,
  input  wire logic        osc_clk_pin,
  // oscillator controls and status
  output logic             osc_run,
  output logic [6:0]       trim_value,
  output logic [4:0]       ulp_trim_value,
  output logic             clk_32k_out,
  output logic             internal_osc_ready,
  output logic             irq
);

  logic [31:0]             ctl;
  logic [7:0]              ulp_ctl;
  logic                    load_pending;
  logic [osc_pkg::IRQ_W-1:0] irq_status;
  logic [osc_pkg::IRQ_W-1:0] irq_mask;
  logic [osc_pkg::IRQ_W-1:0] irq_event;
  logic [osc_pkg::IRQ_W-1:0] next_irq_status;
  logic                    ready_q;
  logic                    ulp_s1;
  logic                    ulp_s2;
  logic                    ulp_s3;
  logic                    osc_s1;
  logic                    osc_s2;
  logic                    next_run;
  logic [31:0]             next_rd_data;
  logic                    ctl_wr;
  logic                    ulp_wr;

  startup_if               link ();

  // field views of the control and ulp registers
  logic                    ctl_enable;
  logic                    ctl_gate;
  logic                    ctl_keep;
  logic                    ctl_on_req;
  logic                    ctl_lock;
  logic                    ulp_lock;

  assign ctl_enable = ctl[osc_pkg::ENABLE_BIT];
  assign ctl_gate   = ctl[osc_pkg::GATE_BIT];
  assign ctl_keep   = ctl[osc_pkg::KEEP_STDBY_BIT];
  assign ctl_on_req = ctl[osc_pkg::ON_REQ_BIT];
  assign ctl_lock   = ctl[osc_pkg::LOCK_BIT];
  assign ulp_lock   = ulp_ctl[osc_pkg::ULP_LOCK_BIT];

  // write decode; a locked register swallows the write silently
  assign ctl_wr = wr && addr == osc_pkg::CTL_OFFSET && !ctl_lock;
  assign ulp_wr = wr && addr == osc_pkg::ULP_OFFSET && !ulp_lock;

  // internal oscillator control register, reserved bits never stored
  always_ff @(posedge clk)
  begin
    if (rst)
      ctl <= osc_pkg::CTL_RESET;
    else if (ctl_wr)
      ctl <= wr_data & osc_pkg::CTL_MASK;
  end

  // one-shot flash load right after reset release
  always_ff @(posedge clk)
  begin
    if (rst)
      load_pending <= 1'b1;
    else
      load_pending <= 1'b0;
  end

  // ulp register: flash load wins over a software write in that one cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      ulp_ctl <= osc_pkg::ULP_RESET;
    else if (load_pending)
      ulp_ctl[osc_pkg::ULP_TRIM_LSB +: osc_pkg::ULP_TRIM_W] <= flash_ulp_trim;
    else if (ulp_wr)
      ulp_ctl <= wr_data[7:0] & osc_pkg::ULP_MASK;
  end

  assign trim_value     = ctl[osc_pkg::TRIM_LSB +: osc_pkg::TRIM_W];
  assign ulp_trim_value = ulp_ctl[osc_pkg::ULP_TRIM_LSB +: osc_pkg::ULP_TRIM_W];

  // run decision: standby without keep bit overrides everything else
  always_comb
  begin
    next_run = ctl_enable;
    if (standby_sleep && !ctl_keep)
      next_run = 1'b0;
    else if (ctl_on_req && !peripheral_request)
      next_run = 1'b0;
  end

  // with on-request clear the request input is simply not looked at
  always_ff @(posedge clk)
  begin
    if (rst)
      osc_run <= 1'b0;
    else
      osc_run <= next_run;
  end

  // ulp clock pin: two-stage synchroniser, edge taken after the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ulp_s1 <= 1'b0;
      ulp_s2 <= 1'b0;
      ulp_s3 <= 1'b0;
    end
    else
    begin
      ulp_s1 <= ulp_clk_pin;
      ulp_s2 <= ulp_s1;
      ulp_s3 <= ulp_s2;
    end
  end

  assign link.run    = osc_run;
  assign link.tick   = ulp_s2 && !ulp_s3;
  assign link.select = ctl[osc_pkg::SEL_LSB +: osc_pkg::SEL_W];

  startup_counter u_startup (
    .clk  (clk),
    .rst  (rst),
    .link (link.counter)
  );

  assign internal_osc_ready = link.ready;

  // oscillator clock pin synchronised, then gated; 32 kHz is far below clk/2
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      osc_s1      <= 1'b0;
      osc_s2      <= 1'b0;
      clk_32k_out <= 1'b0;
    end
    else
    begin
      osc_s1      <= osc_clk_pin;
      osc_s2      <= osc_s1;
      clk_32k_out <= osc_s2 && ctl_gate && osc_run;
    end
  end

  // ready edges become interrupt events
  always_ff @(posedge clk)
  begin
    if (rst)
      ready_q <= 1'b0;
    else
      ready_q <= link.ready;
  end

  always_comb
  begin
    irq_event = '0;
    irq_event[osc_pkg::IRQ_READY_SET_BIT]  = link.ready && !ready_q;
    irq_event[osc_pkg::IRQ_READY_LOST_BIT] = !link.ready && ready_q;
  end

  // write-one-to-clear; a new event in the clearing cycle still sets the bit
  always_comb
  begin
    next_irq_status = irq_status;
    if (wr && addr == osc_pkg::IRQ_STATUS_OFFSET)
      next_irq_status = irq_status & ~wr_data[osc_pkg::IRQ_W-1:0];
    next_irq_status = next_irq_status | irq_event;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      irq_status <= '0;
    else
      irq_status <= next_irq_status;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      irq_mask <= '0;
    else if (wr && addr == osc_pkg::IRQ_MASK_OFFSET)
      irq_mask <= wr_data[osc_pkg::IRQ_W-1:0];
  end

  // registered output: follows status and mask one cycle late
  always_ff @(posedge clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  // read mux; unmapped offsets read as zero
  always_comb
  begin
    next_rd_data = 32'h00000000;
    case (addr)
      osc_pkg::CTL_OFFSET:        next_rd_data = ctl & osc_pkg::CTL_MASK;
      osc_pkg::ULP_OFFSET:        next_rd_data = {24'h000000, ulp_ctl & osc_pkg::ULP_MASK};
      osc_pkg::IRQ_STATUS_OFFSET: next_rd_data[osc_pkg::IRQ_W-1:0] = irq_status;
      osc_pkg::IRQ_MASK_OFFSET:   next_rd_data[osc_pkg::IRQ_W-1:0] = irq_mask;
      osc_pkg::STATUS_OFFSET:     next_rd_data[osc_pkg::STATUS_READY_BIT] = link.ready;
      default:                    next_rd_data = 32'h00000000;
    endcase
  end

  // data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk)
  begin
    if (rst)
      rd_data <= 32'h00000000;
    else if (rd)
      rd_data <= next_rd_data;
    else
      rd_data <= 32'h00000000;
  end

  // checks next to the logic
  a_disabled_stops: assert property (@(posedge clk) disable iff (rst)
    !ctl_enable |=> !osc_run)
    else $error("oscillator runs while disabled");

  a_on_request_idle: assert property (@(posedge clk) disable iff (rst)
    (ctl_on_req && !peripheral_request) |=> !osc_run)
    else $error("on-request oscillator runs without request");

  a_always_on: assert property (@(posedge clk) disable iff (rst)
    (ctl_enable && !ctl_on_req && (!standby_sleep || ctl_keep)) |=> osc_run)
    else $error("enabled oscillator not running continuously");

  a_standby_stop: assert property (@(posedge clk) disable iff (rst)
    (standby_sleep && !ctl_keep) |=> !osc_run)
    else $error("oscillator runs in standby without keep bit");

  a_standby_request: assert property (@(posedge clk) disable iff (rst)
    (standby_sleep && ctl_keep && ctl_enable && ctl_on_req && peripheral_request)
      |=> osc_run)
    else $error("standby request did not run oscillator");

  a_gate_blocks: assert property (@(posedge clk) disable iff (rst)
    !ctl_gate |=> !clk_32k_out)
    else $error("32k output passes while gated");

  a_ctl_locked: assert property (@(posedge clk) disable iff (rst)
    ctl_lock |=> ctl_lock && $stable(ctl))
    else $error("locked control register changed");

  a_ulp_locked: assert property (@(posedge clk) disable iff (rst)
    (ulp_lock && !load_pending) |=> ulp_lock && $stable(ulp_ctl))
    else $error("locked ulp register changed");

  a_reset_value: assert property (@(posedge clk)
    $past(rst) |-> ctl == osc_pkg::CTL_RESET && !ulp_lock)
    else $error("control register reset value wrong");

  // load_pending is also high in reset; the sampled rst keeps the release edge out
  a_flash_load: assert property (@(posedge clk) disable iff (rst)
    (load_pending && !rst) |=> ulp_trim_value == $past(flash_ulp_trim))
    else $error("ulp trim not loaded from flash");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == osc_pkg::CTL_OFFSET) |=> (rd_data & ~osc_pkg::CTL_MASK) == 32'h0)
    else $error("reserved control bits read nonzero");

  a_event_kept: assert property (@(posedge clk) disable iff (rst)
    (|irq_event) |=> (irq_status & $past(irq_event)) == $past(irq_event))
    else $error("interrupt event lost");

  // read port, write and stop checks
  a_ulp_reserved: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == osc_pkg::ULP_OFFSET) |=> (rd_data & ~{24'h000000, osc_pkg::ULP_MASK}) == 32'h0)
    else $error("reserved ulp bits read nonzero");

  a_stop_clears: assert property (@(posedge clk) disable iff (rst)
    $fell(osc_run) |=> !internal_osc_ready)
    else $error("ready flag kept after oscillator stop");

  a_read_idle: assert property (@(posedge clk) disable iff (rst)
    !rd |=> rd_data == 32'h00000000)
    else $error("read data present without read strobe");

  a_trim_write: assert property (@(posedge clk) disable iff (rst)
    ctl_wr |=> trim_value == $past(wr_data[osc_pkg::TRIM_LSB +: osc_pkg::TRIM_W]))
    else $error("trim value not taken from write");

  a_mask_write: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == osc_pkg::IRQ_MASK_OFFSET) |=> irq_mask == $past(wr_data[osc_pkg::IRQ_W-1:0]))
    else $error("interrupt mask not taken from write");

  c_lock_write: cover property (@(posedge clk) disable iff (rst)
    ctl_lock && wr && addr == osc_pkg::CTL_OFFSET);
  c_standby_keep: cover property (@(posedge clk) disable iff (rst)
    standby_sleep && ctl_keep && osc_run);
  c_irq_raised: cover property (@(posedge clk) disable iff (rst) $rose(irq));
  c_on_request_run: cover property (@(posedge clk) disable iff (rst)
    ctl_on_req && peripheral_request && osc_run);

endmodule : internal_32k_osc_control

/* rtl/osc_pkg.sv */
/*
  Constants, register map, field layout and state encoding shared by the
  internal 32 kHz oscillator control block and its start-up counter.
  Assumes byte offsets on an 8-bit register address and 32-bit data.
*/
package osc_pkg;

  // register byte offsets
  localparam logic [7:0]  IRQ_STATUS_OFFSET = 8'h04;
  localparam logic [7:0]  IRQ_MASK_OFFSET   = 8'h08;
  localparam logic [7:0]  STATUS_OFFSET     = 8'h0C;
  localparam logic [7:0]  CTL_OFFSET        = 8'h18;
  localparam logic [7:0]  ULP_OFFSET        = 8'h1C;

  // internal_32k_osc_control fields
  localparam int          ENABLE_BIT        = 1;
  localparam int          GATE_BIT          = 2;
  localparam int          KEEP_STDBY_BIT    = 6;
  localparam int          ON_REQ_BIT        = 7;
  localparam int          SEL_LSB           = 8;
  localparam int          SEL_W             = 3;
  localparam int          LOCK_BIT          = 12;
  localparam int          TRIM_LSB          = 16;
  localparam int          TRIM_W            = 7;
  localparam logic [31:0] CTL_RESET         = 32'h003F0080;
  localparam logic [31:0] CTL_MASK          = 32'h007F17C6;

  // ultra_low_power_osc_control fields
  localparam int          ULP_TRIM_LSB      = 0;
  localparam int          ULP_TRIM_W        = 5;
  localparam int          ULP_LOCK_BIT      = 7;
  localparam logic [7:0]  ULP_RESET         = 8'h00;
  localparam logic [7:0]  ULP_MASK          = 8'h9F;

  // interrupt and status bits
  localparam int          IRQ_W             = 2;
  localparam int          IRQ_READY_SET_BIT = 0;
  localparam int          IRQ_READY_LOST_BIT = 1;
  localparam int          STATUS_READY_BIT  = 0;

  // start-up lengths in ultra-low-power clock ticks, then sync ticks
  localparam int          CNT_W             = 8;
  localparam logic [7:0]  STARTUP_TICKS [8] = '{8'h03, 8'h04, 8'h06, 8'h0A,
                                                8'h12, 8'h22, 8'h42, 8'h82};
  localparam logic [7:0]  SYNC_TICKS        = 8'h02;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_COUNT = 4'h2,
    ST_SYNC  = 4'h4,
    ST_READY = 4'h8
  } startup_state_t;

endpackage : osc_pkg

/* rtl/startup_if.sv */
/*
  Carrier between the oscillator control block and its start-up counter.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ns
interface startup_if;
  logic       run;     // oscillator running request
  logic       tick;    // one-cycle pulse per ultra-low-power clock rising edge
  logic [2:0] select;  // start-up length code
  logic       ready;   // oscillator ready, decoded from the state register
  modport ctrl    (output run, output tick, output select, input ready);
  modport counter (input run, input tick, input select, output ready);
endinterface : startup_if

/* rtl/startup_counter.sv */
/*
  Start-up counter of the internal oscillator, advanced by ticks of the
  ultra-low-power oscillator. Assumes tick is already synchronised.
*/
`timescale 1ns/1ns
module startup_counter (
  input wire logic clk,
  input wire logic rst,
  startup_if.counter link
);

  osc_pkg::startup_state_t        state;
  logic [osc_pkg::CNT_W-1:0]      count;
  logic [osc_pkg::CNT_W-1:0]      span;
  logic [osc_pkg::CNT_W-1:0]      want;

  // stopping drops back to idle at once, so every restart recounts in full
  always_ff @(posedge clk)
  begin
    if (rst || !link.run)
    begin
      state <= osc_pkg::ST_IDLE;
      count <= '0;
    end
    else
    begin
      case (state)
        osc_pkg::ST_IDLE:
        begin
          state <= osc_pkg::ST_COUNT;
          count <= osc_pkg::STARTUP_TICKS[link.select];
        end
        osc_pkg::ST_COUNT:
          if (link.tick)
          begin
            if (count == 8'h01)
            begin
              state <= osc_pkg::ST_SYNC;
              count <= osc_pkg::SYNC_TICKS;
            end
            else
              count <= count - 8'h01;
          end
        osc_pkg::ST_SYNC:
          if (link.tick)
          begin
            if (count == 8'h01)
              state <= osc_pkg::ST_READY;
            else
              count <= count - 8'h01;
          end
        osc_pkg::ST_READY:
          state <= osc_pkg::ST_READY;
        default:
          state <= osc_pkg::ST_IDLE;
      endcase
    end
  end

  assign link.ready = (state == osc_pkg::ST_READY);

  // helper: ticks seen from leaving idle until ready is reached
  always_ff @(posedge clk)
  begin
    if (rst || state == osc_pkg::ST_IDLE)
      span <= '0;
    else if (link.tick && state != osc_pkg::ST_READY)
      span <= span + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (rst || state == osc_pkg::ST_IDLE)
      want <= osc_pkg::STARTUP_TICKS[link.select] + osc_pkg::SYNC_TICKS;
  end

  a_startup_length: assert property (@(posedge clk) disable iff (rst)
    $rose(link.ready) |-> span == want)
    else $error("start-up length differs from selected code");
  a_ready_needs_run: assert property (@(posedge clk) disable iff (rst)
    !link.run |=> !link.ready)
    else $error("ready flag held while oscillator stopped");
  c_ready_reached: cover property (@(posedge clk) disable iff (rst) $rose(link.ready));

endmodule : startup_counter

/* tb/tb_top.sv */
/*
  Self-checking bench for the internal 32 kHz oscillator control block.
  Assumes the block answers reads one cycle after rd and that both raw
  oscillator pins may be driven from the bench clock domain.
*/
`timescale 1ns/1ns
module tb_top;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wr_data;
  logic        wr;
  logic        rd;
  logic [31:0] rd_data;
  logic        peripheral_request;
  logic        standby_sleep;
  logic [4:0]  flash_ulp_trim;
  logic        ulp_clk_pin;
  logic        osc_clk_pin;
  logic        osc_run;
  logic [6:0]  trim_value;
  logic [4:0]  ulp_trim_value;
  logic        clk_32k_out;
  logic        internal_osc_ready;
  logic        irq;
  logic [3:0]  ucnt;
  int          err_count;
  int          n_checks;
  int          k;
  int          tg;
  // run table: enable, on-request, keep-in-standby, standby, request, expected run
  logic [5:0]  rows [9];

  internal_32k_osc_control DUT (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr(wr), .rd(rd),
    .rd_data(rd_data), .peripheral_request(peripheral_request),
    .standby_sleep(standby_sleep), .flash_ulp_trim(flash_ulp_trim),
    .ulp_clk_pin(ulp_clk_pin), .osc_clk_pin(osc_clk_pin), .osc_run(osc_run),
    .trim_value(trim_value), .ulp_trim_value(ulp_trim_value),
    .clk_32k_out(clk_32k_out), .internal_osc_ready(internal_osc_ready), .irq(irq)
  );

  always #5 clk = ~clk;

  // slow oscillators from a free counter: ulp period 16 cycles, osc period 4
  always @(posedge clk)
  begin
    ucnt        <= ucnt + 4'h1;
    ulp_clk_pin <= ucnt[3];
    osc_clk_pin <= ucnt[1];
  end

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : check

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr      <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk);
    wr      <= 1'b0;
  endtask : wr_reg

  // read data stand in the cycle after the strobe is taken, so sample just past that edge
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask : rd_chk

  // aligns the enable a few cycles after a ulp edge so tick counting is unambiguous
  task run_startup(input int code);
    int   i;
    int   cnt;
    logic prev;
    wr_reg(osc_pkg::CTL_OFFSET, 32'h0);
    prev = 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      #1;
      if (ulp_clk_pin === 1'b1 && prev === 1'b0)
        break;
      prev = ulp_clk_pin;
    end
    if (i == 40)
    begin
      err_count++;
      end_sim();
    end
    repeat (4) @(posedge clk);
    wr_reg(osc_pkg::CTL_OFFSET, 32'h2 | (32'(code) << 8));
    cnt  = 0;
    prev = ulp_clk_pin;
    for (i = 0; i < 3000 && internal_osc_ready !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
      if (osc_run === 1'b1 && ulp_clk_pin === 1'b1 && prev === 1'b0)
        cnt++;
      prev = ulp_clk_pin;
    end
    if (i == 3000)
    begin
      err_count++;
      end_sim();
    end
    check(32'(cnt), (32'h1 << code) + 32'h4);
    rd_chk(osc_pkg::STATUS_OFFSET, 32'h1);
    wr_reg(osc_pkg::CTL_OFFSET, 32'h0);
    repeat (3) @(posedge clk);
    #1;
    check(32'(internal_osc_ready), 32'h0);
  endtask : run_startup

  initial
  begin
    clk = 0; rst = 1; addr = 0; wr_data = 0; wr = 0; rd = 0; ucnt = 0;
    peripheral_request = 0; standby_sleep = 0; flash_ulp_trim = 5'h15;
    ulp_clk_pin = 0; osc_clk_pin = 0; err_count = 0; n_checks = 0;
    rows = '{6'b000010, 6'b100001, 6'b110000, 6'b110011, 6'b100110,
             6'b101101, 6'b111100, 6'b111111, 6'b110110};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(osc_pkg::CTL_OFFSET, 32'h003F0080);
    check(32'(trim_value), 32'h3F);
    rd_chk(osc_pkg::ULP_OFFSET, 32'h15);
    // every writable bit set except the lock, enable and gate; reserved places must read back zero
    wr_reg(osc_pkg::CTL_OFFSET, 32'hFFFFEFF9);
    rd_chk(osc_pkg::CTL_OFFSET, 32'h007F07C0);
    wr_reg(osc_pkg::ULP_OFFSET, 32'h0000007F);
    rd_chk(osc_pkg::ULP_OFFSET, 32'h1F);
    rd_chk(8'h40, 32'h0);
    // run decision table
    for (k = 0; k < 9; k++)
    begin
      wr_reg(osc_pkg::CTL_OFFSET, {24'h0, rows[k][4], rows[k][3], 4'h0, rows[k][5], 1'b0});
      standby_sleep      <= rows[k][2];
      peripheral_request <= rows[k][1];
      repeat (4) @(posedge clk);
      #1;
      check(32'(osc_run), 32'(rows[k][0]));
    end
    @(posedge clk);
    standby_sleep      <= 1'b0;
    peripheral_request <= 1'b0;
    // start-up length for every code, each one a full restart
    wr_reg(osc_pkg::IRQ_MASK_OFFSET, 32'h3);
    for (k = 0; k < 8; k++)
      run_startup(k);
    check(32'(irq), 32'h1);
    rd_chk(osc_pkg::IRQ_STATUS_OFFSET, 32'h3);
    wr_reg(osc_pkg::IRQ_STATUS_OFFSET, 32'h3);
    repeat (2) @(posedge clk);
    #1;
    check(32'(irq), 32'h0);
    // masked events stay sticky but keep irq low until unmasked
    wr_reg(osc_pkg::IRQ_MASK_OFFSET, 32'h0);
    run_startup(0);
    check(32'(irq), 32'h0);
    wr_reg(osc_pkg::IRQ_MASK_OFFSET, 32'h2);
    repeat (2) @(posedge clk);
    #1;
    check(32'(irq), 32'h1);
    wr_reg(osc_pkg::IRQ_STATUS_OFFSET, 32'h3);
    // output gate with trim written by software
    wr_reg(osc_pkg::CTL_OFFSET, 32'h00550006);
    repeat (4) @(posedge clk);
    check(32'(trim_value), 32'h55);
    tg = 0;
    for (k = 0; k < 40; k++)
    begin
      @(posedge clk);
      #1;
      if (clk_32k_out === 1'b1)
        tg++;
    end
    check(32'(tg > 0 && tg < 40), 32'h1);
    wr_reg(osc_pkg::CTL_OFFSET, 32'h00550002);
    repeat (4) @(posedge clk);
    tg = 0;
    for (k = 0; k < 40; k++)
    begin
      @(posedge clk);
      #1;
      if (clk_32k_out !== 1'b0)
        tg++;
    end
    check(32'(tg), 32'h0);
    // locks freeze both registers, the lock bits included
    wr_reg(osc_pkg::CTL_OFFSET, 32'h00551002);
    wr_reg(osc_pkg::CTL_OFFSET, 32'h0);
    rd_chk(osc_pkg::CTL_OFFSET, 32'h00551002);
    wr_reg(osc_pkg::ULP_OFFSET, 32'h8A);
    wr_reg(osc_pkg::ULP_OFFSET, 32'h0);
    rd_chk(osc_pkg::ULP_OFFSET, 32'h8A);
    check(32'(ulp_trim_value), 32'h0A);
    // a second reset lifts the locks
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(osc_pkg::CTL_OFFSET, 32'h003F0080);
    wr_reg(osc_pkg::CTL_OFFSET, 32'h0);
    rd_chk(osc_pkg::CTL_OFFSET, 32'h0);
    rd_chk(osc_pkg::ULP_OFFSET, 32'h15);
    end_sim();
  end
endmodule : tb_top
